// File: shared/pod_consts.vh
// Constants for the privileged opcode decoder
`ifndef POD_CONSTS_VH
`define POD_CONSTS_VH

// ****************************************
// Primary opcodes
// ****************************************
`define POD_OP_CALL        6'h00
`define POD_OP_IPR_READ    6'h19
`define POD_OP_PRIV_LOAD   6'h1B
`define POD_OP_IPR_WRITE   6'h1D
`define POD_OP_PRIV_RETURN 6'h1E
`define POD_OP_PRIV_STORE  6'h1F

// ****************************************
// Required call function codes
// ****************************************
`define POD_FN_HALT        26'h0000000
`define POD_FN_DRAIN       26'h0000002
`define POD_FN_IBARRIER    26'h0000086

// ****************************************
// Instruction field positions
// ****************************************
`define POD_OPC_HI         31
`define POD_OPC_LO         26
`define POD_RA_HI          25
`define POD_RA_LO          21
`define POD_RB_HI          20
`define POD_RB_LO          16
`define POD_UNTRANS_BIT    15
`define POD_OTHER_BIT      14
`define POD_WRCHK_BIT      13
`define POD_QUAD_BIT       12
`define POD_PTW_BIT        11
`define POD_RSV_BIT        10
`define POD_OFFS_HI        9
`define POD_OFFS_W         10
`define POD_VAR_HI         15
`define POD_VAR_LO         14
`define POD_VAR_NORMAL     2'h2
`define POD_VAR_STALL      2'h3
`define POD_IPR_UNIT_HI    9
`define POD_IPR_UNIT_LO    8
`define POD_IPR_UNIT_FDU   2'h0

// ****************************************
// Latencies, modes, registers
// ****************************************
`define POD_LAT_FDU        2'h1
`define POD_LAT_MTU        2'h2
`define POD_MODE_KERNEL    2'h0
`define POD_REG_ZERO       5'h1F
`define POD_OFS_CTRL       8'h00
`define POD_OFS_TRAP_RET   8'h04
`define POD_OFS_STATUS     8'h08
`define POD_CTRL_RST       32'h00000001
`define POD_CTRL_PCM_RST   1'b1
`define POD_CTRL_PCM       0
`define POD_CTRL_KHE       1
`define POD_CTRL_DTM_LO    2
`define POD_CTRL_SUB_LO    4
`define POD_CTRL_CUR_LO    6
`define POD_STAT_ILL       0

`endif

// File: hdl/pod_ret_stack.v
// Return prediction stack with registered top-of-stack output
`timescale 1ns/1ns
`default_nettype none

module pod_ret_stack #(
   parameter PC_W  = 32,
   parameter DEPTH = 8,
   parameter PTR_W = 3
) (
   input  wire            clk_sys,
   input  wire            rst,
   input  wire            push,
   input  wire [PC_W-1:0] push_pc,
   input  wire            pop,
   output reg  [PC_W-1:0] top_r,
   output reg             empty_r
);

   reg [PC_W-1:0]  mem [0:DEPTH-1];
   reg [PTR_W-1:0] sp_r;
   reg [PTR_W:0]   cnt_r;
   wire [PTR_W-1:0] sp_dn = sp_r - 1'b1;
   wire [PTR_W-1:0] sp_dn2 = sp_r - 2'h2;

   // Wraps when full: oldest prediction is simply overwritten
   always @(posedge clk_sys) begin
      if (push) begin
         mem[sp_r] <= push_pc;
      end
   end

   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         sp_r    <= {PTR_W{1'b0}};
         cnt_r   <= {(PTR_W+1){1'b0}};
         top_r   <= {PC_W{1'b0}};
         empty_r <= 1'b1;
      end else if (push) begin
         sp_r    <= sp_r + 1'b1;
         top_r   <= push_pc;
         empty_r <= 1'b0;
         if (cnt_r != DEPTH[PTR_W:0]) begin
            cnt_r <= cnt_r + 1'b1;
         end
      end else if (pop && !empty_r) begin
         sp_r    <= sp_dn;
         top_r   <= mem[sp_dn2];
         cnt_r   <= cnt_r - 1'b1;
         empty_r <= (cnt_r == {{PTR_W{1'b0}}, 1'b1});
      end
   end

endmodule // pod_ret_stack

`default_nettype wire

// File: hdl/pod_decoder.v
// Privileged opcode decoder with APB control registers
//
// Summary of operation
// - Recognise drain-aborts and halt as privileged calls, barrier as unprivileged.
// - Opcode 1B decodes as the privileged load.
// - Opcode 1F decodes as the privileged store.
// - Opcode 1E decodes as the privileged return to trap return address.
// - Opcode 19 reads, 1D writes internal registers in three units.
// - Reserved opcodes trap outside privileged mode unless kernel enable in kernel.
// - Dependency checks and bypassing apply to these instructions' general registers.
// - Alignment traps suppressed for privileged load and store.
// - Untranslated bit makes the address physical, skipping translation and checks.
// - Other-mode bit picks substitute mode instead of current translation mode.
// - Write-check clear makes loads check reads only; set, or any store, checks reads and writes.
// - Add signed 10-bit displacement to base; size bit picks quadword.
// - Page-walk load checks in kernel mode and flags double miss.
// - Reserve-load does a locked load, placed in integer pipe 0.
// - Privileged store always goes to integer pipe 0.
// - Conditional store writes the reservation flag into the data register.
// - Return jumps to trap return address, bit 0 sets privileged mode.
// - Return target predicted from the return prediction stack.
// - Normal return starts fetching the new stream before it issues.
// - Stall return holds fetch until issue; one per aligned group of four.
// - Privileged return goes to integer pipe 1.
// - Fetch-unit register reads land one cycle later, others two cycles.
//
// Register access over APB and the register offsets are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
`include "pod_consts.vh"

module pod_decoder #(
   parameter DATA_W = 64,
   parameter PC_W   = 32,
   parameter RPS_D  = 8,
   parameter RPS_PW = 3
) (
   input  wire              clk_sys,
   input  wire              rst,
   // APB slave
   input  wire              psel,
   input  wire              penable,
   input  wire              pwrite,
   input  wire [7:0]        paddr,
   input  wire [31:0]       pwdata,
   output wire              pready,
   output reg  [31:0]       prdata,
   output reg               pslverr,
   // Decode stage
   input  wire              instr_valid,
   input  wire [31:0]       instr,
   input  wire              issue_ack,
   input  wire [DATA_W-1:0] base_val,
   input  wire              ext_hazard,
   input  wire              lock_flag,
   input  wire              call_push,
   input  wire [PC_W-1:0]   call_ret_pc,
   output wire              is_priv_load,
   output wire              is_priv_store,
   output wire              is_priv_return,
   output wire              is_ipr_read_instr,
   output wire              is_ipr_write_instr,
   output wire              drain_aborts_call,
   output wire              halt_call,
   output wire              istream_barrier_call,
   output wire              illegal_op_trap,
   output wire              pipe_sel_1,
   output wire              decode_stall,
   output wire              bypass_ra,
   output wire              bypass_rb,
   output wire              align_trap_suppress,
   output wire              untranslated,
   output wire              skip_access_check,
   output wire [1:0]        check_mode,
   output wire              chk_fault_read,
   output wire              chk_fault_write,
   output wire              chk_read_viol,
   output wire              chk_write_viol,
   output wire              quad_size,
   output wire              pte_fetch,
   output wire              load_locked,
   output wire              store_store_if_reserved_bit,
   output wire              ra_gets_lock_flag,
   output wire [DATA_W-1:0] eff_addr,
   output wire              ipr_fdu_unit,
   output wire [1:0]        ipr_latency,
   output wire              fetch_redirect,
   output wire [PC_W-1:0]   fetch_target,
   output reg               fetch_hold_r,
   output reg               ret_jump_r,
   output reg  [PC_W-1:0]   ret_target_r,
   output reg               ipr_data_ready_r,
   output wire              priv_code_mode
);

   // ****************************************
   // Control registers
   // ****************************************
   reg              pcm_r;
   reg              khe_r;
   reg [1:0]        dtm_r;
   reg [1:0]        sub_r;
   reg [1:0]        cur_r;
   reg [PC_W-1:0]   trap_return_pc_r;
   reg              ill_seen_r;

   wire apb_wr = psel && penable && pwrite;
   wire apb_rd_setup = psel && !penable && !pwrite;

   function hit;
      input [7:0] a;
      begin
         hit = (a == `POD_OFS_CTRL) || (a == `POD_OFS_TRAP_RET) || (a == `POD_OFS_STATUS);
      end
   endfunction

   // Zero-wait slave: every access phase completes at once
   assign pready = psel && penable;

   // ****************************************
   // Field extraction
   // ****************************************
   wire [5:0] opc = instr[`POD_OPC_HI:`POD_OPC_LO];
   wire [4:0] ra  = instr[`POD_RA_HI:`POD_RA_LO];
   wire [4:0] rb  = instr[`POD_RB_HI:`POD_RB_LO];
   wire [1:0] ret_var = instr[`POD_VAR_HI:`POD_VAR_LO];
   wire [25:0] fn = instr[25:0];

   assign is_priv_load       = instr_valid && (opc == `POD_OP_PRIV_LOAD);
   assign is_priv_store      = instr_valid && (opc == `POD_OP_PRIV_STORE);
   assign is_priv_return     = instr_valid && (opc == `POD_OP_PRIV_RETURN);
   assign is_ipr_read_instr  = instr_valid && (opc == `POD_OP_IPR_READ);
   assign is_ipr_write_instr = instr_valid && (opc == `POD_OP_IPR_WRITE);
   wire   is_mem = is_priv_load || is_priv_store;

   wire is_call = instr_valid && (opc == `POD_OP_CALL);
   assign drain_aborts_call    = is_call && (fn == `POD_FN_DRAIN);
   assign halt_call            = is_call && (fn == `POD_FN_HALT);
   assign istream_barrier_call = is_call && (fn == `POD_FN_IBARRIER);

   // ****************************************
   // Privilege check
   // ****************************************
   wire in_kernel = (cur_r == `POD_MODE_KERNEL);
   wire reserved_op = is_mem || is_priv_return || is_ipr_read_instr || is_ipr_write_instr;
   wire may_use_reserved = pcm_r || (khe_r && in_kernel);
   wire priv_call_bad = (drain_aborts_call || halt_call) && !pcm_r && !in_kernel;
   assign illegal_op_trap = (reserved_op && !may_use_reserved) || priv_call_bad;
   assign priv_code_mode = pcm_r;

   // ****************************************
   // Pipe slotting
   // ****************************************
   wire ipr_fdu = (instr[`POD_IPR_UNIT_HI:`POD_IPR_UNIT_LO] == `POD_IPR_UNIT_FDU);
   assign ipr_fdu_unit = (is_ipr_read_instr || is_ipr_write_instr) && ipr_fdu;
   // Return to pipe 1; store and locked load to pipe 0; fetch-unit IPRs on pipe 1
   assign pipe_sel_1 = is_priv_return || ipr_fdu_unit;

   // ****************************************
   // Memory option bits
   // ****************************************
   wire ub  = instr[`POD_UNTRANS_BIT];
   wire ob  = instr[`POD_OTHER_BIT];
   wire wc  = instr[`POD_WRCHK_BIT];
   wire ptw = is_priv_load && instr[`POD_PTW_BIT];

   assign align_trap_suppress = is_mem;
   assign untranslated        = is_mem && ub;
   assign skip_access_check   = is_mem && ub;
   assign pte_fetch           = ptw;
   assign check_mode = ptw ? `POD_MODE_KERNEL : (ob ? sub_r : dtm_r);
   wire do_chk = is_mem && !ub;
   wire chk_w  = is_priv_store || (is_priv_load && wc);
   assign chk_fault_read  = do_chk;
   assign chk_read_viol   = do_chk;
   assign chk_fault_write = do_chk && chk_w;
   assign chk_write_viol  = do_chk && chk_w;
   assign quad_size       = is_mem && instr[`POD_QUAD_BIT];
   assign load_locked     = is_priv_load && instr[`POD_RSV_BIT];
   assign store_store_if_reserved_bit      = is_priv_store && instr[`POD_RSV_BIT];
   assign ra_gets_lock_flag = store_store_if_reserved_bit && lock_flag;

   function [DATA_W-1:0] sext_offs;
      input [`POD_OFFS_W-1:0] d;
      begin
         sext_offs = {{(DATA_W-`POD_OFFS_W){d[`POD_OFFS_HI]}}, d};
      end
   endfunction

   assign eff_addr = base_val + sext_offs(instr[`POD_OFFS_HI:0]);

   // ****************************************
   // Dependency tracking for IPR reads
   // ****************************************
   reg       pend_vld_r;
   reg [4:0] pend_reg_r;
   reg [1:0] pend_cnt_r;

   assign ipr_latency = ipr_fdu ? `POD_LAT_FDU : `POD_LAT_MTU;

   function src_match;
      input [4:0] r;
      input       used;
      begin
         src_match = used && (r != `POD_REG_ZERO) && pend_vld_r && (r == pend_reg_r);
      end
   endfunction

   wire use_ra = is_priv_store || is_ipr_write_instr;
   wire use_rb = is_mem;
   wire ra_m = src_match(ra, use_ra);
   wire rb_m = src_match(rb, use_rb);
   wire not_ready = (pend_cnt_r != 2'h0);
   // Same interlock as ordinary GPR users; internal IPR side effects are not interlocked
   assign decode_stall = ((ra_m || rb_m) && not_ready) || (reserved_op && ext_hazard);
   assign bypass_ra = ra_m && !not_ready;
   assign bypass_rb = rb_m && !not_ready;

   wire read_issue = is_ipr_read_instr && issue_ack && !illegal_op_trap;

   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         pend_vld_r       <= 1'b0;
         pend_reg_r       <= 5'h00;
         pend_cnt_r       <= 2'h0;
         ipr_data_ready_r <= 1'b0;
      end else if (read_issue) begin
         pend_vld_r       <= (ra != `POD_REG_ZERO);
         pend_reg_r       <= ra;
         pend_cnt_r       <= ipr_latency - 2'h1;
         ipr_data_ready_r <= (ipr_latency == `POD_LAT_FDU);
      end else begin
         ipr_data_ready_r <= pend_vld_r && (pend_cnt_r == 2'h1);
         if (pend_cnt_r != 2'h0) begin
            pend_cnt_r <= pend_cnt_r - 2'h1;
         end else begin
            pend_vld_r <= 1'b0;
         end
      end
   end

   // ****************************************
   // Return handling and prefetch control
   // ****************************************
   wire [PC_W-1:0] rps_top;
   wire            rps_empty;
   wire ret_ok    = is_priv_return && !illegal_op_trap;
   wire ret_issue = ret_ok && issue_ack;
   wire ret_stall_var = (ret_var == `POD_VAR_STALL);

   pod_ret_stack #(
      .PC_W  (PC_W),
      .DEPTH (RPS_D),
      .PTR_W (RPS_PW)
   ) u_rps (
      .clk_sys (clk_sys),
      .rst     (rst),
      .push    (call_push),
      .push_pc (call_ret_pc),
      .pop     (ret_issue),
      .top_r   (rps_top),
      .empty_r (rps_empty)
   );

   // Early redirect from prediction; an empty stack falls back to the register
   assign fetch_redirect = ret_ok && !ret_stall_var && !fetch_hold_r;
   assign fetch_target = rps_empty ? trap_return_pc_r : rps_top;

   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         fetch_hold_r <= 1'b0;
         ret_jump_r   <= 1'b0;
         ret_target_r <= {PC_W{1'b0}};
      end else begin
         ret_jump_r <= ret_issue;
         if (ret_issue) begin
            ret_target_r <= trap_return_pc_r;
         end
         // Software keeps to one stall return per aligned group of four
         if (ret_issue) begin
            fetch_hold_r <= 1'b0;
         end else if (ret_ok && ret_stall_var) begin
            fetch_hold_r <= 1'b1;
         end
      end
   end

   // ****************************************
   // Register writes and status
   // ****************************************
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         pcm_r            <= `POD_CTRL_PCM_RST;
         khe_r            <= 1'b0;
         dtm_r            <= 2'h0;
         sub_r            <= 2'h0;
         cur_r            <= 2'h0;
         trap_return_pc_r <= {PC_W{1'b0}};
         ill_seen_r       <= 1'b0;
      end else begin
         if (apb_wr && (paddr == `POD_OFS_CTRL)) begin
            khe_r <= pwdata[`POD_CTRL_KHE];
            dtm_r <= pwdata[`POD_CTRL_DTM_LO+1:`POD_CTRL_DTM_LO];
            sub_r <= pwdata[`POD_CTRL_SUB_LO+1:`POD_CTRL_SUB_LO];
            cur_r <= pwdata[`POD_CTRL_CUR_LO+1:`POD_CTRL_CUR_LO];
         end
         // A return in the same cycle overrides a software write of the mode bit
         if (ret_issue) begin
            pcm_r <= trap_return_pc_r[0];
         end else if (apb_wr && (paddr == `POD_OFS_CTRL)) begin
            pcm_r <= pwdata[`POD_CTRL_PCM];
         end
         if (apb_wr && (paddr == `POD_OFS_TRAP_RET)) begin
            trap_return_pc_r <= pwdata[PC_W-1:0];
         end
         // Set beats write-one-to-clear
         if (illegal_op_trap) begin
            ill_seen_r <= 1'b1;
         end else if (apb_wr && (paddr == `POD_OFS_STATUS) && pwdata[`POD_STAT_ILL]) begin
            ill_seen_r <= 1'b0;
         end
      end
   end

   // ****************************************
   // APB read data, captured in setup phase
   // ****************************************
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         prdata  <= 32'h00000000;
         pslverr <= 1'b0;
      end else if (psel && !penable) begin
         pslverr <= !hit(paddr);
         prdata  <= 32'h00000000;
         if (apb_rd_setup) begin
            case (paddr)
               `POD_OFS_CTRL: begin
                  prdata <= {24'h000000, cur_r, sub_r, dtm_r, khe_r, pcm_r};
               end
               `POD_OFS_TRAP_RET: begin
                  prdata <= {{(32-PC_W){1'b0}}, trap_return_pc_r};
               end
               `POD_OFS_STATUS: begin
                  prdata <= {28'h0000000, rps_empty, pend_vld_r, fetch_hold_r, ill_seen_r};
               end
               default: begin
                  prdata <= 32'h00000000;
               end
            endcase
         end
      end
   end

endmodule // pod_decoder

`default_nettype wire

// File: tb/pod_decoder_props.sv
// Port-level assertions for the privileged opcode decoder
`timescale 1ns/1ns
`default_nettype none
module pod_decoder_props #(
   parameter DATA_W = 64
) (
   input wire logic              clk_sys,
   input wire logic              rst,
   input wire logic              instr_valid,
   input wire logic [31:0]       instr,
   input wire logic              issue_ack,
   input wire logic [DATA_W-1:0] base_val,
   input wire logic [DATA_W-1:0] eff_addr,
   input wire logic              is_priv_load,
   input wire logic              is_priv_store,
   input wire logic              is_priv_return,
   input wire logic              is_ipr_read_instr,
   input wire logic              load_locked,
   input wire logic              pipe_sel_1,
   input wire logic              illegal_op_trap,
   input wire logic              align_trap_suppress,
   input wire logic              priv_code_mode,
   input wire logic              fetch_redirect,
   input wire logic              fetch_hold_r,
   input wire logic              ret_jump_r,
   input wire logic [1:0]        ipr_latency,
   input wire logic              ipr_data_ready_r
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   wire ipr_go = issue_ack && is_ipr_read_instr && !illegal_op_trap;
   property p_ld_dec; instr_valid |-> is_priv_load == (instr[31:26] == 6'h1B); endproperty
   a_ld_dec: assert property (p_ld_dec) else $error("load decode wrong");
   property p_st_pipe; is_priv_store |-> !pipe_sel_1; endproperty
   a_st_pipe: assert property (p_st_pipe) else $error("store not in pipe 0");
   property p_ret_pipe; is_priv_return |-> pipe_sel_1; endproperty
   a_ret_pipe: assert property (p_ret_pipe) else $error("return not in pipe 1");
   property p_lock_pipe; load_locked |-> !pipe_sel_1; endproperty
   a_lock_pipe: assert property (p_lock_pipe) else $error("locked load not in pipe 0");
   property p_align; is_priv_load || is_priv_store |-> align_trap_suppress; endproperty
   a_align: assert property (p_align) else $error("alignment trap not suppressed");
   property p_legal; is_priv_load && priv_code_mode |-> !illegal_op_trap; endproperty
   a_legal: assert property (p_legal) else $error("trap in privileged mode");
   property p_eff; instr_valid |-> eff_addr == base_val + {{(DATA_W-10){instr[9]}}, instr[9:0]}; endproperty
   a_eff: assert property (p_eff) else $error("effective address wrong");
   property p_jump; issue_ack && is_priv_return && !illegal_op_trap |=> ret_jump_r; endproperty
   a_jump: assert property (p_jump) else $error("no jump after return");
   property p_hold; is_priv_return && instr[15:14] == 2'h3 && !illegal_op_trap && !issue_ack |=> fetch_hold_r; endproperty
   a_hold: assert property (p_hold) else $error("fetch not held");
   property p_hold_redir; fetch_hold_r |-> !fetch_redirect; endproperty
   a_hold_redir: assert property (p_hold_redir) else $error("redirect while held");
   property p_release; fetch_hold_r && issue_ack && is_priv_return |=> !fetch_hold_r; endproperty
   a_release: assert property (p_release) else $error("hold not released");
   property p_lat1; ipr_go && ipr_latency == 2'h1 |=> ipr_data_ready_r; endproperty
   a_lat1: assert property (p_lat1) else $error("short read late");
   property p_lat2; ipr_go && ipr_latency == 2'h2 |-> ##2 ipr_data_ready_r; endproperty
   a_lat2: assert property (p_lat2) else $error("long read late");
endmodule // pod_decoder_props
`default_nettype wire

// File: tb/pod_issue_model.sv
// Issue stage model facing the decoder
`timescale 1ns/1ns
`default_nettype none
module pod_issue_model (
   input  wire logic clk_sys,
   input  wire logic rst,
   input  wire logic en,
   input  wire logic instr_valid,
   input  wire logic decode_stall,
   input  wire logic load_locked,
   input  wire logic store_store_if_reserved_bit,
   output logic      issue_ack,
   output logic      lock_flag
);
   logic lock_flag_r;
   // Never issues into a stall; spacing is left to the stimulus
   assign issue_ack = en & instr_valid & ~decode_stall;
   assign lock_flag = lock_flag_r;
   always @(posedge clk_sys or posedge rst) begin
      if (rst)
         lock_flag_r <= 1'h0;
      else if (issue_ack && load_locked)
         lock_flag_r <= 1'h1;
      else if (issue_ack && store_store_if_reserved_bit)
         lock_flag_r <= 1'h0;
   end
endmodule // pod_issue_model
`default_nettype wire

// File: tb/privileged_opcode_decoder_tb.sv
// Self-checking bench for the privileged opcode decoder
`timescale 1ns/1ns
`default_nettype none
`include "pod_consts.vh"
module privileged_opcode_decoder_tb;
   localparam DATA_W = 64;
   localparam NOP    = 32'h40000000;
   logic        clk_sys = 1'h0, rst = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
   logic        instr_valid = 1'h0, en = 1'h0, call_push = 1'h0, ext_hazard = 1'h0, e;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, instr = 32'h0, call_ret_pc = 32'h0, q;
   logic [63:0] base_val = 64'h1000, eff_addr;
   logic        pready, pslverr, is_priv_load, is_priv_store, is_priv_return, is_ipr_read_instr;
   logic        is_ipr_write_instr, drain_aborts_call, halt_call, istream_barrier_call, illegal_op_trap;
   logic        pipe_sel_1, decode_stall, bypass_ra, bypass_rb, align_trap_suppress, untranslated;
   logic        skip_access_check, chk_fault_read, chk_fault_write, chk_read_viol, chk_write_viol;
   logic        quad_size, pte_fetch, load_locked, store_store_if_reserved_bit, ra_gets_lock_flag, ipr_fdu_unit;
   logic        fetch_redirect, fetch_hold_r, ret_jump_r, ipr_data_ready_r, priv_code_mode;
   logic        issue_ack, lock_flag;
   logic [31:0] prdata, fetch_target, ret_target_r;
   logic [1:0]  check_mode, ipr_latency;
   int          mismatches = 0, tests_run = 0, cyc = 0, k;
   wire         ls = is_priv_load | is_priv_store;
   // Instruction, then expected flags, with control set to 32'h25
   logic [55:0] rows [11] = '{
      {32'h6C009000, 24'h803850},
      {32'h6C006000, 24'h80202D},
      {32'h6C000E00, 24'h802609},
      {32'h7C004403, 24'h40212D},
      {32'h78008000, 24'h204002},
      {32'h64000000, 24'h104000},
      {32'h74000100, 24'h080000},
      {32'h00000002, 24'h040000},
      {32'h00000000, 24'h020000},
      {32'h00000086, 24'h010000},
      {NOP, 24'h000000}
   };
   // Control value, instruction, expected trap
   logic [64:0] ill [5] = '{
      {32'h24, 32'h6C000000, 1'h1}, {32'h26, 32'h6C000000, 1'h0}, {32'h66, 32'h6C000000, 1'h1},
      {32'h66, 32'h00000000, 1'h1}, {32'h66, 32'h00000086, 1'h0}
   };

   pod_decoder u_dut (.*);
   pod_issue_model u_partner (.*);

   initial begin
      forever #5 clk_sys = ~clk_sys;
   end

   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         mismatches++;
         close_out;
      end
   end

   task chk(input string n, input logic [63:0] x, input logic [63:0] a);
      tests_run++;
      if (a !== x) begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", n, x, a);
      end
   endtask

   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      psel <= 1'h1;
      penable <= 1'h0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'h1;
      @(posedge clk_sys);
      while (pready !== 1'h1) @(posedge clk_sys);
      q = prdata;
      e = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask

   task put(input logic [31:0] i, input logic iss);
      @(posedge clk_sys);
      instr_valid <= 1'h1;
      instr <= i;
      en <= iss;
      #1;
   endtask

   // Counts cycles from issue until read data lands
   task ipr(input logic [31:0] i, input logic [31:0] f, input int lat, input logic st);
      put(i, 1'h1);
      chk("fdu_unit", lat == 1, ipr_fdu_unit);
      k = 0;
      for (int n = 1; n <= 3; n++) begin
         put(n < 3 ? f : NOP, 1'h0);
         if (n == 1) chk("stall", st, decode_stall);
         if (n == 2) chk("bypass", {2{st}}, {bypass_ra, bypass_rb});
         if (k == 0 && ipr_data_ready_r === 1'h1) k = n;
      end
      chk("latency", lat, k);
   endtask

   task close_out;
      if (mismatches == 0 && tests_run > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   initial begin
      repeat (10) @(posedge clk_sys);
      rst <= 1'h0;
      chk("reset_mode", 1'h1, priv_code_mode);
      apb(1'h0, `POD_OFS_CTRL, 32'h0);
      chk("ctrl_reset", `POD_CTRL_RST, q);
      apb(1'h0, 8'h0C, 32'h0);
      chk("unmapped", 1'h1, e);
      apb(1'h1, `POD_OFS_CTRL, 32'h25);
      foreach (rows[i]) begin
         put(rows[i][55:24], 1'h0);
         chk("decode", rows[i][23:0], {is_priv_load, is_priv_store, is_priv_return, is_ipr_read_instr,
            is_ipr_write_instr, drain_aborts_call, halt_call, istream_barrier_call, illegal_op_trap,
            pipe_sel_1, align_trap_suppress, untranslated & ls, quad_size & ls, pte_fetch, load_locked,
            store_store_if_reserved_bit, ra_gets_lock_flag, skip_access_check, check_mode & {2{ls}}, chk_fault_read,
            chk_fault_write, fetch_redirect, chk_read_viol});
         chk("eff_addr", base_val + {{54{rows[i][33]}}, rows[i][33:24]}, eff_addr);
      end
      foreach (ill[i]) begin
         apb(1'h1, `POD_OFS_CTRL, ill[i][64:33]);
         put(ill[i][32:1], 1'h0);
         chk("illegal", ill[i][0], illegal_op_trap);
      end
      apb(1'h1, `POD_OFS_CTRL, 32'h25);
      apb(1'h1, `POD_OFS_TRAP_RET, 32'h100);
      apb(1'h0, `POD_OFS_TRAP_RET, 32'h0);
      chk("trap_ret", 32'h100, q);
      @(posedge clk_sys);
      call_push <= 1'h1;
      call_ret_pc <= 32'h200;
      @(posedge clk_sys);
      call_push <= 1'h0;
      put(32'h78008000, 1'h1);
      chk("predicted", 32'h200, fetch_target);
      put(NOP, 1'h0);
      chk("jump", 3'h5, {ret_jump_r, priv_code_mode, ret_target_r == 32'h100});
      apb(1'h1, `POD_OFS_CTRL, 32'h25);
      put(32'h7800C000, 1'h0);
      put(32'h7800C000, 1'h0);
      chk("held", 2'h2, {fetch_hold_r, fetch_redirect});
      put(32'h7800C000, 1'h1);
      put(NOP, 1'h0);
      chk("released", 2'h1, {fetch_hold_r, ret_jump_r});
      apb(1'h1, `POD_OFS_CTRL, 32'h25);
      put(32'h6C000400, 1'h1);
      put(32'h7C000400, 1'h0);
      chk("lock_flag", 2'h3, {ra_gets_lock_flag, chk_write_viol});
      ipr(32'h64000000, NOP, 1, 1'h0);
      ipr(32'h64A50100, 32'h7CA50000, 2, 1'h1);
      close_out;
   end
endmodule // privileged_opcode_decoder_tb

bind pod_decoder pod_decoder_props #(.DATA_W(DATA_W)) u_props (.*);
`default_nettype wire
